// >>> logic/swg_pkg.sv
// Package: constants, carriers and state codes for the supervisor, watchdog and chip-enable gate
// Function
// - Reset output low while the selected undervoltage indication is present.
// - Reset held a further 200ms after undervoltage clears.
// - Active-high reset is always the inverse of active-low reset.
// - Mode select grounded gives internal mode; 600mV or more gives external.
// - Low-line output low on the low-line indication of the selected mode.
// - Overvoltage flag low while sense is high; it affects nothing else.
// - Timeout select tied high gives the 1.6s default watchdog timeout.
// - Capacitor timeout scales with nF: 27ms at 5V, 16.2ms at 3V.
// - Kick input constant beyond the timeout asserts watchdog fault low.
// - Watchdog fault stays low until the next kick edge of either polarity.
// - Watchdog timeout drives the warning pulse low for at least 500us.
// - Warning pulse falls about 70ns before the watchdog fault asserts.
// - Gated chip enable low only when input low and either reset inactive or in the onset grace.
// - Chip enable low at reset onset stays low up to 15us or input high.
// - Manual reset held low at least 25us; hold-off starts on release.
// - During reset the watchdog counters clear and both watchdog outputs are forced high.
// - During reset, after the onset grace, the chip-enable input is ignored and the output held high.
package swg_pkg;
    localparam int unsigned CLK_HZ = 250_000_000;
    localparam real HOLD_MS = 200.0;
    localparam real WD_DEF_S = 1.6;
    localparam real WD_K5_MS = 27.0;
    localparam real WD_K3_MS = 16.2;
    localparam real WARN_US = 500.0;
    localparam real LEAD_NS = 70.0;
    localparam real CE_GRACE_US = 15.0;
    localparam int unsigned HOLD_CYC = int'(HOLD_MS * CLK_HZ / 1.0e3);
    localparam int unsigned WD_DEF_CYC = int'(WD_DEF_S * CLK_HZ);
    localparam int unsigned WD_K5_CYC = int'(WD_K5_MS * CLK_HZ / 1.0e3);
    localparam int unsigned WD_K3_CYC = int'(WD_K3_MS * CLK_HZ / 1.0e3);
    localparam int unsigned WARN_CYC = int'($ceil(WARN_US * CLK_HZ / 1.0e6));
    localparam int unsigned LEAD_CYC = int'($floor(LEAD_NS * CLK_HZ / 1.0e9));
    localparam int unsigned CE_GRACE_CYC = int'($floor(CE_GRACE_US * CLK_HZ / 1.0e6));
    localparam int WD_W = 40;
    localparam int CE_W = 12;
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] CTRL_OFF = 8'h00;
    localparam logic [ADDR_W-1:0] CAP_OFF = 8'h04;
    localparam logic [ADDR_W-1:0] STAT_OFF = 8'h08;
    localparam int CTRL_SUP5_BIT = 0;
    localparam logic CTRL_RST = 1'h1;
    localparam logic [15:0] CAP_RST = 16'h0001;
    localparam int ST_RST = 0;
    localparam int ST_LOWLINE = 1;
    localparam int ST_OV = 2;
    localparam int ST_FAULT = 3;
    localparam int ST_WARN = 4;
    localparam int ST_MODE = 5;
    localparam int ST_CE = 6;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {SEL_CTRL = 2'b00, SEL_CAP = 2'b01, SEL_STAT = 2'b10, SEL_NONE = 2'b11} swg_sel_t;
    typedef enum logic [1:0] {CE_PASS = 2'b00, CE_GRACE = 2'b01, CE_BLOCK = 2'b10} swg_ce_st_t;
    typedef struct packed {
        logic awvalid; logic [ADDR_W-1:0] awaddr; logic wvalid; logic [31:0] wdata;
        logic [3:0] wstrb; logic bready; logic arvalid; logic [ADDR_W-1:0] araddr; logic rready;
    } swg_axi_req_t;
    typedef struct packed {
        logic awready; logic wready; logic bvalid; logic [1:0] bresp;
        logic arready; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
    } swg_axi_rsp_t;
    typedef struct packed {
        logic vcc_below_rst; logic rst_sense_low; logic mode_ext; logic vcc_lowline; logic supply_warn_sense;
        logic overvolt_sense; logic manual_reset_n; logic wd_kick; logic timeout_select; logic ce_in_n;
    } swg_sense_t;
    localparam swg_sense_t SENSE_RST = 10'h36b;
    typedef struct packed {
        logic rst_n; logic rst; logic lowline_n; logic ovflag_n;
        logic wd_fault_n; logic wd_warn_pulse_n; logic ce_out_n;
    } swg_pins_t;
endpackage

// >>> logic/swg_sync.sv
// Three-flop input synchroniser whose output follows once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module swg_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_q, s2_q, s3_q, q_q, q_d;
    always_comb
    begin
        q_d = (s2_q & s3_q) | (q_q & (s2_q | s3_q));
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s1_q <= RST;
            s2_q <= RST;
            s3_q <= RST;
            q_q <= RST;
        end
        else
        begin
            s1_q <= d;
            s2_q <= s1_q;
            s3_q <= s2_q;
            q_q <= q_d;
        end
    end
    assign q = q_q;
endmodule
`default_nettype wire

// >>> logic/swg_ce_gate.sv
// Chip-enable gate with write-completion grace at reset onset
`timescale 1ns/1ps
`default_nettype none
module swg_ce_gate
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic rst_act,
    input wire logic ce_in_n,
    output logic ce_out_n
);
    swg_pkg::swg_ce_st_t st_q, st_d;
    logic [swg_pkg::CE_W-1:0] cnt_q, cnt_d;
    logic out_q, out_d;
    always_comb
    begin
        st_d = st_q;
        cnt_d = cnt_q;
        out_d = out_q;
        case (st_q)
            swg_pkg::CE_PASS:
            begin
                if (rst_act && !ce_in_n)
                begin
                    st_d = swg_pkg::CE_GRACE;
                    cnt_d = '0;
                    out_d = 1'b0;
                end
                else if (rst_act)
                begin
                    st_d = swg_pkg::CE_BLOCK;
                    out_d = 1'b1;
                end
                else
                begin
                    out_d = ce_in_n;
                end
            end
            swg_pkg::CE_GRACE:
            begin
                if (!rst_act)
                begin
                    st_d = swg_pkg::CE_PASS;
                    out_d = ce_in_n;
                end
                else if (ce_in_n || cnt_q == swg_pkg::CE_W'(swg_pkg::CE_GRACE_CYC - 1))
                begin
                    st_d = swg_pkg::CE_BLOCK;
                    out_d = 1'b1;
                end
                else
                begin
                    cnt_d = cnt_q + swg_pkg::CE_W'(1);
                end
            end
            swg_pkg::CE_BLOCK:
            begin
                out_d = 1'b1;
                if (!rst_act)
                begin
                    st_d = swg_pkg::CE_PASS;
                end
            end
            default:
            begin
                st_d = swg_pkg::CE_BLOCK;
                out_d = 1'b1;
            end
        endcase
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_q <= swg_pkg::CE_BLOCK;
            cnt_q <= '0;
            out_q <= 1'b1;
        end
        else
        begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            out_q <= out_d;
        end
    end
    assign ce_out_n = out_q;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_ce_block: assert property (st_q == swg_pkg::CE_BLOCK && rst_act |=> out_q) else $error("ce not blocked");
    chk_ce_pass: assert property (st_q == swg_pkg::CE_PASS && !rst_act |=> out_q == $past(ce_in_n)) else $error("ce not passed");
    chk_ce_grace: assert property (st_q == swg_pkg::CE_GRACE |-> !out_q && cnt_q < swg_pkg::CE_GRACE_CYC) else $error("ce grace bad");
    cov_ce_grace: cover property (st_q == swg_pkg::CE_GRACE ##1 st_q == swg_pkg::CE_BLOCK);
endmodule
`default_nettype wire

// >>> logic/swg_supervisor.sv
// Supervisor top: reset generation, low-line and overvoltage flags, watchdog, AXI4-Lite registers
//
// The register addresses and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module swg_supervisor #(
    parameter int unsigned HOLD_CYC = swg_pkg::HOLD_CYC,
    parameter int unsigned WD_DEF_CYC = swg_pkg::WD_DEF_CYC,
    parameter int unsigned WD_K5_CYC = swg_pkg::WD_K5_CYC,
    parameter int unsigned WD_K3_CYC = swg_pkg::WD_K3_CYC,
    parameter int unsigned WARN_CYC = swg_pkg::WARN_CYC
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire swg_pkg::swg_axi_req_t axi_req,
    output var swg_pkg::swg_axi_rsp_t axi_rsp,
    input wire swg_pkg::swg_sense_t sense,
    output var swg_pkg::swg_pins_t pins
);
    localparam int unsigned LEAD = swg_pkg::LEAD_CYC;
    localparam int W = swg_pkg::WD_W;

    swg_pkg::swg_sense_t syn;
    logic uv, lowline, rst_act;
    logic [31:0] hold_q, hold_d;
    logic rst_n_q, rst_n_d, rst_q, rst_d, lowline_n_q, lowline_n_d, ov_n_q, ov_n_d;
    logic kick_prev_q, kick_prev_d, kick_edge;
    logic [W-1:0] wd_cnt_q, wd_cnt_d, lim;
    logic fault_n_q, fault_n_d, warn_n_q, warn_n_d;
    logic [31:0] warn_cnt_q, warn_cnt_d;
    logic ce_out_n;
    logic aw_have_q, aw_have_d, w_have_q, w_have_d;
    logic [swg_pkg::ADDR_W-1:0] awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;
    logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic sup5_q, sup5_d;
    logic [15:0] cap_q, cap_d;

    function automatic swg_pkg::swg_sel_t reg_sel(input logic [swg_pkg::ADDR_W-1:0] addr);
        case (addr)
            swg_pkg::CTRL_OFF: return swg_pkg::SEL_CTRL;
            swg_pkg::CAP_OFF: return swg_pkg::SEL_CAP;
            swg_pkg::STAT_OFF: return swg_pkg::SEL_STAT;
            default: return swg_pkg::SEL_NONE;
        endcase
    endfunction

    function automatic logic [W-1:0] wd_limit(input logic tsel, input logic sup5, input logic [15:0] nf);
        logic [W-1:0] l;
        l = W'(WD_DEF_CYC);
        if (!tsel)
        begin
            l = W'(nf) * W'(sup5 ? WD_K5_CYC : WD_K3_CYC);
        end
        if (l < W'(LEAD + 2))
        begin
            l = W'(LEAD + 2);
        end
        return l;
    endfunction

    // Manual reset input idles high through the synchroniser reset value
    swg_sync #(.W($bits(swg_pkg::swg_sense_t)), .RST(swg_pkg::SENSE_RST)) u_sync
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .d(sense),
        .q(syn)
    );

    always_comb
    begin
        uv = syn.mode_ext ? syn.rst_sense_low : syn.vcc_below_rst;
        lowline = syn.mode_ext ? syn.supply_warn_sense : syn.vcc_lowline;
        hold_d = hold_q;
        if (uv || !syn.manual_reset_n)
        begin
            hold_d = '0;
        end
        else if (hold_q < HOLD_CYC)
        begin
            hold_d = hold_q + 32'h1;
        end
        rst_act = uv || !syn.manual_reset_n || (hold_q < HOLD_CYC);
        rst_d = rst_act;
        rst_n_d = !rst_act;
        lowline_n_d = !lowline;
        ov_n_d = !syn.overvolt_sense;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            hold_q <= '0;
            rst_q <= 1'b1;
            rst_n_q <= 1'b0;
            lowline_n_q <= 1'b0;
            ov_n_q <= 1'b1;
        end
        else
        begin
            hold_q <= hold_d;
            rst_q <= rst_d;
            rst_n_q <= rst_n_d;
            lowline_n_q <= lowline_n_d;
            ov_n_q <= ov_n_d;
        end
    end

    always_comb
    begin
        lim = wd_limit(syn.timeout_select, sup5_q, cap_q);
        kick_edge = syn.wd_kick != kick_prev_q;
        kick_prev_d = syn.wd_kick;
        wd_cnt_d = wd_cnt_q;
        fault_n_d = fault_n_q;
        warn_n_d = warn_n_q;
        warn_cnt_d = warn_cnt_q;
        if (rst_q)
        begin
            wd_cnt_d = '0;
            fault_n_d = 1'b1;
            warn_n_d = 1'b1;
            warn_cnt_d = '0;
        end
        else
        begin
            if (!warn_n_q)
            begin
                if (warn_cnt_q == WARN_CYC - 1)
                begin
                    warn_n_d = 1'b1;
                end
                else
                begin
                    warn_cnt_d = warn_cnt_q + 32'h1;
                end
            end
            if (kick_edge)
            begin
                wd_cnt_d = '0;
                fault_n_d = 1'b1;
            end
            else
            begin
                if (wd_cnt_q < lim)
                begin
                    wd_cnt_d = wd_cnt_q + W'(1);
                end
                if (wd_cnt_q == lim - W'(LEAD + 1))
                begin
                    warn_n_d = 1'b0;
                    warn_cnt_d = '0;
                end
                if (wd_cnt_q == lim - W'(1))
                begin
                    fault_n_d = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            kick_prev_q <= 1'b0;
            wd_cnt_q <= '0;
            fault_n_q <= 1'b1;
            warn_n_q <= 1'b1;
            warn_cnt_q <= '0;
        end
        else
        begin
            kick_prev_q <= kick_prev_d;
            wd_cnt_q <= wd_cnt_d;
            fault_n_q <= fault_n_d;
            warn_n_q <= warn_n_d;
            warn_cnt_q <= warn_cnt_d;
        end
    end

    swg_ce_gate u_ce
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .rst_act(rst_q),
        .ce_in_n(syn.ce_in_n),
        .ce_out_n(ce_out_n)
    );

    // Write path accepts address and data in either order, then answers once both are held
    always_comb
    begin
        aw_have_d = aw_have_q;
        awaddr_d = awaddr_q;
        w_have_d = w_have_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        sup5_d = sup5_q;
        cap_d = cap_q;
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (axi_req.awvalid && awready_q)
        begin
            aw_have_d = 1'b1;
            awaddr_d = axi_req.awaddr;
        end
        if (axi_req.wvalid && wready_q)
        begin
            w_have_d = 1'b1;
            wdata_d = axi_req.wdata;
            wstrb_d = axi_req.wstrb;
        end
        if (bvalid_q && axi_req.bready)
        begin
            bvalid_d = 1'b0;
        end
        if (aw_have_q && w_have_q && !bvalid_q)
        begin
            aw_have_d = 1'b0;
            w_have_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = swg_pkg::RESP_OKAY;
            case (reg_sel(awaddr_q))
                swg_pkg::SEL_CTRL:
                begin
                    if (wstrb_q[0])
                    begin
                        sup5_d = wdata_q[swg_pkg::CTRL_SUP5_BIT];
                    end
                end
                swg_pkg::SEL_CAP:
                begin
                    if (wstrb_q[0])
                    begin
                        cap_d[7:0] = wdata_q[7:0];
                    end
                    if (wstrb_q[1])
                    begin
                        cap_d[15:8] = wdata_q[15:8];
                    end
                end
                swg_pkg::SEL_STAT:
                begin
                    bresp_d = swg_pkg::RESP_OKAY;
                end
                default:
                begin
                    bresp_d = swg_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (rvalid_q && axi_req.rready)
        begin
            rvalid_d = 1'b0;
        end
        if (axi_req.arvalid && arready_q)
        begin
            rvalid_d = 1'b1;
            rresp_d = swg_pkg::RESP_OKAY;
            rdata_d = '0;
            case (reg_sel(axi_req.araddr))
                swg_pkg::SEL_CTRL:
                begin
                    rdata_d[swg_pkg::CTRL_SUP5_BIT] = sup5_q;
                end
                swg_pkg::SEL_CAP:
                begin
                    rdata_d[15:0] = cap_q;
                end
                swg_pkg::SEL_STAT:
                begin
                    rdata_d[swg_pkg::ST_RST] = rst_q;
                    rdata_d[swg_pkg::ST_LOWLINE] = !lowline_n_q;
                    rdata_d[swg_pkg::ST_OV] = !ov_n_q;
                    rdata_d[swg_pkg::ST_FAULT] = !fault_n_q;
                    rdata_d[swg_pkg::ST_WARN] = !warn_n_q;
                    rdata_d[swg_pkg::ST_MODE] = syn.mode_ext;
                    rdata_d[swg_pkg::ST_CE] = !ce_out_n;
                end
                default:
                begin
                    rresp_d = swg_pkg::RESP_SLVERR;
                end
            endcase
        end
        awready_d = !aw_have_d && !bvalid_d;
        wready_d = !w_have_d && !bvalid_d;
        arready_d = !rvalid_d;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_q <= 1'b0;
            awaddr_q <= '0;
            w_have_q <= 1'b0;
            wdata_q <= '0;
            wstrb_q <= '0;
            bvalid_q <= 1'b0;
            bresp_q <= swg_pkg::RESP_OKAY;
            sup5_q <= swg_pkg::CTRL_RST;
            cap_q <= swg_pkg::CAP_RST;
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= swg_pkg::RESP_OKAY;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            arready_q <= 1'b0;
        end
        else
        begin
            aw_have_q <= aw_have_d;
            awaddr_q <= awaddr_d;
            w_have_q <= w_have_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            sup5_q <= sup5_d;
            cap_q <= cap_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
            arready_q <= arready_d;
        end
    end

    assign axi_rsp = '{awready: awready_q, wready: wready_q, bvalid: bvalid_q, bresp: bresp_q,
                       arready: arready_q, rvalid: rvalid_q, rdata: rdata_q, rresp: rresp_q};
    assign pins = '{rst_n: rst_n_q, rst: rst_q, lowline_n: lowline_n_q, ovflag_n: ov_n_q,
                    wd_fault_n: fault_n_q, wd_warn_pulse_n: warn_n_q, ce_out_n: ce_out_n};

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_rst_inverse: assert property (rst_n_q != rst_q) else $error("reset outputs not inverse");
    chk_uv_reset: assert property (uv |=> !rst_n_q) else $error("undervoltage without reset");
    chk_manual_reset: assert property (!syn.manual_reset_n |=> !rst_n_q ##0 hold_q == 0) else $error("manual reset missed");
    chk_hold_release: assert property ($rose(rst_n_q) |-> $past(hold_q) == HOLD_CYC) else $error("hold-off wrong");
    chk_mode_ext: assert property (syn.mode_ext && syn.supply_warn_sense |=> !lowline_n_q) else $error("ext low-line");
    chk_lowline_int: assert property (!syn.mode_ext && syn.vcc_lowline |=> !lowline_n_q) else $error("int low-line");
    chk_ov_flag: assert property (1'b1 |=> ov_n_q == !$past(syn.overvolt_sense))
        else $error("overvoltage flag wrong");
    chk_fault_timeout: assert property ($fell(fault_n_q) |-> $past(wd_cnt_q) == $past(lim) - 1)
        else $error("fault not at timeout");
    chk_fault_hold: assert property (!fault_n_q && !kick_edge && !rst_q |=> !fault_n_q) else $error("fault released early");
    chk_warn_lead: assert property ($fell(fault_n_q) |-> !warn_n_q && $past(warn_cnt_q) == LEAD - 1)
        else $error("warning lead wrong");
    chk_warn_width: assert property ($rose(warn_n_q) && !$past(rst_q) |-> $past(warn_cnt_q) == WARN_CYC - 1)
        else $error("warning too short");
    chk_wd_quiet: assert property (rst_q |=> fault_n_q && warn_n_q && wd_cnt_q == 0) else $error("watchdog active in reset");
    cov_release: cover property ($rose(rst_n_q));
    cov_fault: cover property ($fell(fault_n_q) ##[1:1000] kick_edge);
    cov_write: cover property (bvalid_q && bresp_q == swg_pkg::RESP_OKAY);
endmodule
`default_nettype wire

// >>> sim/swg_host_model.sv
// Host-side model: processor that kicks the watchdog and a manual reset button
`timescale 1ns/1ps
`default_nettype none
module swg_host_model #(
    parameter int PRESS_CYC = 6250
)
(
    input wire logic aclk,
    input wire logic kick_en,
    input wire logic press,
    input wire logic [7:0] gap,
    output logic wd_kick,
    output logic manual_reset_n
);
    int kick_cnt = 0;
    int press_cnt = 0;
    initial
    begin
        wd_kick = 1'b0;
        manual_reset_n = 1'b1;
    end
    always @(posedge aclk)
    begin
        kick_cnt <= kick_en ? (kick_cnt + 1) % int'(gap) : 0;
        if (kick_en && kick_cnt == 0)
            wd_kick <= ~wd_kick;
        press_cnt <= press ? PRESS_CYC : (press_cnt > 0 ? press_cnt - 1 : 0);
        manual_reset_n <= !(press || press_cnt > 1);
    end
endmodule
`default_nettype wire

// >>> sim/swg_supervisor_tb_top.sv
// Testbench for the supervisor: reset, flags, watchdog timing, chip-enable gate, registers
`timescale 1ns/1ps
`default_nettype none
module swg_supervisor_tb_top;
    localparam int HOLD = 40;
    localparam int WARN = 30;
    // Shortest legal button press: 25us at 4 ns per cycle
    localparam int PRESS = 6250;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic kick_en = 1'b0;
    logic press = 1'b0;
    logic kick;
    logic man_rst_n;
    logic [7:0] gap = 8'h0a;
    logic [31:0] rd;
    logic [1:0] rp;
    int n_errors = 0;
    int comparisons = 0;
    int cyc = 0;
    swg_pkg::swg_axi_req_t rq = '0;
    swg_pkg::swg_axi_rsp_t rs;
    swg_pkg::swg_sense_t sd = 10'h00b;
    swg_pkg::swg_sense_t sn;
    swg_pkg::swg_pins_t pins;
    assign sn = {sd[9:4], man_rst_n, kick, sd[1:0]};
    always #2 aclk = ~aclk;
    swg_supervisor #(.HOLD_CYC(HOLD), .WD_DEF_CYC(200), .WD_K5_CYC(50), .WD_K3_CYC(30), .WARN_CYC(WARN)) u_dut
    (.aclk(aclk), .aresetn(aresetn), .axi_req(rq), .axi_rsp(rs), .sense(sn), .pins(pins));
    swg_host_model #(.PRESS_CYC(PRESS)) u_host
    (.aclk(aclk), .kick_en(kick_en), .press(press), .gap(gap), .wd_kick(kick), .manual_reset_n(man_rst_n));
    function automatic int lim(input int m, input int c);
        return m == 0 ? 200 : (m == 1 ? c * 50 : c * 30);
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e)
        begin
            n_errors++;
            $display("unexpected t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic rng(input int n, input int a, input int b);
        chk(32'(n >= a && n <= b), 32'h1);
    endtask
    task automatic wt(input int i, input logic v, output int n);
        n = 0;
        while (pins[i] !== v && n < 8000)
        begin
            @(posedge aclk);
            n++;
        end
    endtask
    task automatic bus(input bit we, input logic [7:0] a, input logic [31:0] wd);
        @(posedge aclk);
        rq.awvalid <= we;
        rq.wvalid <= we;
        rq.bready <= we;
        rq.arvalid <= !we;
        rq.rready <= !we;
        rq.awaddr <= a;
        rq.araddr <= a;
        rq.wdata <= wd;
        rq.wstrb <= 4'hf;
        do
        begin
            @(posedge aclk);
            if (rs.awready) rq.awvalid <= 1'b0;
            if (rs.wready) rq.wvalid <= 1'b0;
            if (rs.arready) rq.arvalid <= 1'b0;
        end while (!(we ? rs.bvalid : rs.rvalid));
        rq.bready <= 1'b0;
        rq.rready <= 1'b0;
        rd = rs.rdata;
        rp = we ? rs.bresp : rs.rresp;
    endtask
    task automatic summarize;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            n_errors++;
            summarize();
        end
    end
    initial
    begin
        int n, m, w, c;
        void'($urandom(32'hd469));
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        wt(6, 1'b1, n);
        rng(n, HOLD, HOLD + 8);
        bus(0, 8'h04, 0);
        chk(rd, 32'h1);
        bus(0, 8'h10, 0);
        chk({30'h0, rp}, 32'h2);
        bus(1, 8'h10, 32'h5);
        chk({30'h0, rp}, 32'h2);
        for (int md = 0; md < 2; md++)
        begin
            sd.mode_ext <= md[0];
            sd[8 + md] <= 1'b1;
            sd[5 + md] <= 1'b1;
            repeat (10) @(posedge aclk);
            chk(pins[6], 1'b1);
            chk(pins[4], 1'b1);
            sd[9 - md] <= 1'b1;
            sd[6 - md] <= 1'b1;
            repeat (10) @(posedge aclk);
            chk(pins[6], 1'b0);
            chk(pins[5], 1'b1);
            chk(pins[4], 1'b0);
            sd[9:8] <= 2'b00;
            sd[6:5] <= 2'b00;
            wt(6, 1'b1, n);
            rng(n, HOLD, HOLD + 8);
        end
        sd.overvolt_sense <= 1'b1;
        repeat (8) @(posedge aclk);
        chk(pins[3], 1'b0);
        chk(pins[6], 1'b1);
        sd.overvolt_sense <= 1'b0;
        for (int k = 0; k < 3; k++)
        begin
            c = 2 + $urandom % 3;
            gap <= 8'(8 + $urandom % 8);
            bus(1, 8'h04, c);
            bus(0, 8'h04, 0);
            chk(rd, c);
            bus(1, 8'h00, 32'(k == 1));
            sd.timeout_select <= k == 0;
            kick_en <= 1'b1;
            wt(2, 1'b1, n);
            rng(n, 0, 24);
            @(kick);
            kick_en <= 1'b0;
            wt(1, 1'b0, n);
            wt(2, 1'b0, m);
            wt(1, 1'b1, w);
            rng(n + m, lim(k, c), lim(k, c) + 8);
            chk(m, 17);
            chk(m + w, WARN);
            chk(pins[2], 1'b0);
            bus(0, 8'h08, 0);
            chk(rd, (32'h1 << swg_pkg::ST_FAULT) | (32'h1 << swg_pkg::ST_MODE));
        end
        sd.ce_in_n <= 1'b0;
        repeat (8) @(posedge aclk);
        chk(pins[0], 1'b0);
        press <= 1'b1;
        @(posedge aclk);
        press <= 1'b0;
        wt(6, 1'b0, n);
        @(posedge aclk);
        chk(pins[2:1], 2'b11);
        repeat (10) @(posedge aclk);
        chk(pins[0], 1'b0);
        sd.ce_in_n <= 1'b1;
        repeat (8) @(posedge aclk);
        chk(pins[0], 1'b1);
        sd.ce_in_n <= 1'b0;
        repeat (8) @(posedge aclk);
        chk(pins[0], 1'b1);
        wt(6, 1'b1, n);
        rng(n + 34 - PRESS, HOLD + 5, HOLD + 12);
        repeat (8) @(posedge aclk);
        chk(pins[0], 1'b0);
        summarize();
    end
endmodule
`default_nettype wire
